// File: hw/grabber_led_trigger_ctrl.v
// Purpose: LED, trigger routing and frame tagging control bank
// Assumes: APB slave, zero wait states, inputs synchronous
// Notes: frame tagging acts on the primary byte stream
//
// Summary of operation
// - Two-bit source field; zero means slow blink
// - Upper bit only: blink while frame valid
// - Lower bit only: blink while line valid
// - Both bits: steady LED from level bit
// - Bit 2 is level; bits 7-3 unused
// - Select zero: each connector uses own timer
// - Select one: both connectors use timer 0
// - Shared trigger: pin A fires both lines
// - Separate: pin A primary, pin B secondary
// - Count bit tags frame with frame count
// - Marker bit tags frame with FF00
// - Free-run bit makes line width free-run
// - Source zero plus select: pin A frames
// - Invert bit flips pin A frame trigger
// - Source one plus select: pin B frames
// - Secondary window sits 0x40 above primary
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "led_trig_defines.vh"
module grabber_led_trigger_ctrl #(
    parameter integer BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // Camera timing
    input wire fval_in,
    input wire lval_in,
    // Pixel bytes in
    input wire [7:0] pix_data_in,
    input wire pix_sof_in,
    input wire pix_valid_in,
    output wire pix_ready_out,
    // Pixel bytes out
    output wire [7:0] pix_data_out,
    output wire pix_sof_out,
    output wire pix_valid_out,
    input wire pix_ready_in,
    // Trigger pins and shutter timers
    input wire trigger_in_a,
    input wire trigger_in_b,
    input wire [1:0] shutter_in,
    // Connector outputs
    output wire [1:0] exposure_out,
    output wire [1:0] trig_fire_out,
    output wire frame_trig_out,
    output wire [1:0] line_width_freerun_out,
    // Debug LED
    output wire led_out
);
    // Tagger states
    localparam [2:0] ST_IDLE = 3'b001; // Before any frame
    localparam [2:0] ST_B1 = 3'b010; // Second byte next
    localparam [2:0] ST_PASS = 3'b100; // Rest of frame

    // Hit vector bit positions
    localparam integer H_LED = 0;
    localparam integer H_CTL2 = 1;
    localparam integer H_CTL2B = 2;
    localparam integer H_UTIL2 = 3;
    localparam integer H_UTIL3 = 4;
    localparam integer H_PLO = 5;
    localparam integer H_PHI = 6;

    // Software-visible registers
    reg [7:0] led_debug_ctrl_r; // LED source and level
    reg [7:0] link_ctrl_two_r; // Primary control 2
    reg [7:0] link_ctrl_two_secondary_r; // Secondary control 2
    reg [7:0] util2_r; // Trigger select only
    reg [7:0] util3_r; // Trigger invert only
    reg [31:0] prdata_r; // Read data, caught in setup
    reg [31:0] prdata_nxt;

    // Line width measurement
    reg [15:0] ppl_cnt_r; // Bytes this line
    reg [15:0] ppl_r; // Reported width
    reg lval_d_r; // Line valid, one cycle late

    // Frame tagging
    reg [2:0] tag_st_r; // Tagger state
    reg [2:0] tag_st_nxt;
    reg [15:0] frame_cnt_r; // Frames seen
    reg [7:0] tag_data; // Byte after tagging

    // Registered pin outputs
    reg [1:0] exposure_r;
    reg [1:0] exposure_nxt;
    reg [1:0] fire_r;
    reg [1:0] fire_nxt;
    reg frame_trig_r;
    reg frame_trig_nxt;
    reg led_r;
    reg led_nxt;

    // Bus decode and misc nets
    wire [6:0] hit; // One-hot register hit
    wire setup; // APB setup phase
    wire access; // APB access phase
    wire wr_en; // Low byte written
    wire blink; // Slow square wave
    wire in_fire; // Byte accepted
    wire line_end; // Line valid fell
    wire freerun_a;
    wire trigsel;
    wire trig_a_frame; // Pin A, maybe inverted

    // Map a byte address to a one-hot register hit
    function [6:0] reg_hit;
        input [11:0] a;
        begin
            reg_hit = 7'h00;
            if (a[1:0] == 2'b00) begin
                case (a[11:2])
                    `IDX_LED: reg_hit = 7'h01;
                    `IDX_CTL2: reg_hit = 7'h02;
                    `IDX_CTL2_B: reg_hit = 7'h04;
                    `IDX_UTIL2: reg_hit = 7'h08;
                    `IDX_UTIL3: reg_hit = 7'h10;
                    `IDX_PPL_LO: reg_hit = 7'h20;
                    `IDX_PPL_HI: reg_hit = 7'h40;
                    default: reg_hit = 7'h00;
                endcase
            end
        end
    endfunction

    assign hit = reg_hit(paddr_in);
    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    // Only the low lane carries register data
    assign wr_en = access & pwrite_in & pstrb_in[0];

    // Zero wait states keep the master simple
    assign pready_out = 1'b1;
    // Unmapped addresses answer with an error
    assign pslverr_out = access & (hit == 7'h00);
    assign prdata_out = prdata_r;

    // Register writes; unused bits masked to zero
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            led_debug_ctrl_r <= `LED_RST;
            link_ctrl_two_r <= `CTL2_RST;
            link_ctrl_two_secondary_r <= `CTL2_RST;
            util2_r <= `UTIL_RST;
            util3_r <= `UTIL_RST;
        end else if (wr_en) begin
            if (hit[H_LED]) begin
                led_debug_ctrl_r <= pwdata_in[7:0] & `LED_MASK;
            end
            if (hit[H_CTL2]) begin
                link_ctrl_two_r <= pwdata_in[7:0] & `CTL2_MASK;
            end
            if (hit[H_CTL2B]) begin
                // Same layout as the primary copy
                link_ctrl_two_secondary_r <= pwdata_in[7:0] & `CTL2_MASK;
            end
            if (hit[H_UTIL2]) begin
                util2_r <= pwdata_in[7:0] & `UTIL2_MASK;
            end
            if (hit[H_UTIL3]) begin
                util3_r <= pwdata_in[7:0] & `UTIL3_MASK;
            end
        end
    end

    // Read mux, sampled in setup so data comes from a flop
    always @* begin
        prdata_nxt = 32'h0000_0000;
        case (1'b1)
            hit[H_LED]: prdata_nxt[7:0] = led_debug_ctrl_r;
            hit[H_CTL2]: prdata_nxt[7:0] = link_ctrl_two_r;
            hit[H_CTL2B]: prdata_nxt[7:0] = link_ctrl_two_secondary_r;
            hit[H_UTIL2]: prdata_nxt[7:0] = util2_r;
            hit[H_UTIL3]: prdata_nxt[7:0] = util3_r;
            hit[H_PLO]: prdata_nxt[7:0] = ppl_r[7:0];
            hit[H_PHI]: prdata_nxt[7:0] = ppl_r[15:8];
            default: prdata_nxt = 32'h0000_0000;
        endcase
    end

    // Hold read data through the access phase
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= prdata_nxt;
        end
    end

    // Slow blink source shared by all blink modes
    led_blink_div #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .blink_out(blink)
    );

    // LED source select
    always @* begin
        case (led_debug_ctrl_r[`LED_SEL_MSB:`LED_SEL_LSB])
            `LED_SLOW: led_nxt = blink;
            `LED_FVAL: led_nxt = blink & fval_in;
            `LED_LVAL: led_nxt = blink & lval_in;
            `LED_STEADY: led_nxt = led_debug_ctrl_r[`LED_LEVEL];
            default: led_nxt = 1'b0;
        endcase
    end

    // Per-connector exposure and trigger routing
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_conn
            always @* begin
                // Connector 0 always follows module 0
                if (i == 0 || link_ctrl_two_r[`CTL2_EXPSEL]) begin
                    exposure_nxt[i] = shutter_in[0];
                end else begin
                    exposure_nxt[i] = shutter_in[i];
                end
                // Pin B only reaches connector 1 when separate
                if (i == 0 || !link_ctrl_two_r[`CTL2_SEPARATE_TRIGGER_EN]) begin
                    fire_nxt[i] = trigger_in_a;
                end else begin
                    fire_nxt[i] = trigger_in_b;
                end
            end
        end
    endgenerate

    // Frame trigger pin choice; invert applies to pin A only
    assign trigsel = util2_r[`UTIL2_TRIGSEL];
    assign trig_a_frame = trigger_in_a ^ util3_r[`UTIL3_INV];
    always @* begin
        frame_trig_nxt = 1'b0;
        if (trigsel) begin
            if (link_ctrl_two_r[`CTL2_FRMSRC]) begin
                frame_trig_nxt = trigger_in_b;
            end else begin
                frame_trig_nxt = trig_a_frame;
            end
        end
    end

    // Pin outputs registered to keep them glitch free
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            exposure_r <= 2'b00;
            fire_r <= 2'b00;
            frame_trig_r <= 1'b0;
            led_r <= 1'b0;
        end else begin
            exposure_r <= exposure_nxt;
            fire_r <= fire_nxt;
            frame_trig_r <= frame_trig_nxt;
            led_r <= led_nxt;
        end
    end

    assign exposure_out = exposure_r;
    assign trig_fire_out = fire_r;
    assign frame_trig_out = frame_trig_r;
    assign led_out = led_r;
    assign line_width_freerun_out[0] = link_ctrl_two_r[`CTL2_FREERUN];
    assign line_width_freerun_out[1] = link_ctrl_two_secondary_r[`CTL2_FREERUN];
    assign freerun_a = link_ctrl_two_r[`CTL2_FREERUN];

    // Bytes enter the buffer only when it has room
    assign in_fire = pix_valid_in & pix_ready_out;
    assign line_end = lval_d_r & ~lval_in;

    // Tagger next state; start of frame always restarts it
    always @* begin
        case (tag_st_r)
            ST_IDLE: tag_st_nxt = ST_IDLE;
            ST_B1: tag_st_nxt = ST_PASS;
            ST_PASS: tag_st_nxt = ST_PASS;
            default: tag_st_nxt = ST_IDLE;
        endcase
        if (in_fire && pix_sof_in) begin
            tag_st_nxt = ST_B1;
        end else if (!in_fire) begin
            tag_st_nxt = tag_st_r;
        end
    end

    // Overwrite the first two bytes; count wins over marker
    always @* begin
        tag_data = pix_data_in;
        if (pix_sof_in) begin
            if (link_ctrl_two_r[`CTL2_COUNT]) begin
                tag_data = frame_cnt_r[7:0];
            end else if (link_ctrl_two_r[`CTL2_MARK]) begin
                tag_data = `MARK_B0;
            end
        end else if (tag_st_r == ST_B1) begin
            if (link_ctrl_two_r[`CTL2_COUNT]) begin
                tag_data = frame_cnt_r[15:8];
            end else if (link_ctrl_two_r[`CTL2_MARK]) begin
                tag_data = `MARK_B1;
            end
        end
    end

    // Tagger state and frame counter
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tag_st_r <= ST_IDLE;
            frame_cnt_r <= 16'h0000;
        end else begin
            tag_st_r <= tag_st_nxt;
            // Counter steps after the second byte is tagged
            if (in_fire && tag_st_r == ST_B1 && !pix_sof_in) begin
                frame_cnt_r <= frame_cnt_r + 16'h0001;
            end
        end
    end

    // Line width: latched per line, or live when free-running
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ppl_cnt_r <= 16'h0000;
            ppl_r <= 16'h0000;
            lval_d_r <= 1'b0;
        end else begin
            lval_d_r <= lval_in;
            if (freerun_a) begin
                // Never cleared; reads track the running count
                if (in_fire && lval_in) begin
                    ppl_cnt_r <= ppl_cnt_r + 16'h0001;
                end
                ppl_r <= ppl_cnt_r;
            end else if (line_end) begin
                ppl_r <= ppl_cnt_r;
                ppl_cnt_r <= 16'h0000;
            end else if (in_fire && lval_in) begin
                ppl_cnt_r <= ppl_cnt_r + 16'h0001;
            end
        end
    end

    // Buffer so a stalled receiver loses no byte
    pix_buf2 #(
        .WIDTH(9)
    ) u_buf (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_data_in({pix_sof_in, tag_data}),
        .in_valid_in(pix_valid_in),
        .in_ready_out(pix_ready_out),
        .out_data_out({pix_sof_out, pix_data_out}),
        .out_valid_out(pix_valid_out),
        .out_ready_in(pix_ready_in)
    );
endmodule // grabber_led_trigger_ctrl

// File: hw/led_blink_div.v
// Purpose: free-running slow blink divider
// Assumes: HALF_CYC at least 1
// Notes: period is 2 x HALF_CYC cycles
`timescale 1ns/1ps
`include "led_trig_defines.vh"
module led_blink_div #(
    parameter integer HALF_CYC = `BLINK_HALF_CYC
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_in,
    // Square wave
    output wire blink_out
);
    reg [`BLINK_CNT_W-1:0] cnt_r; // Cycles in this half
    reg blink_r; // Current phase
    wire wrap; // Half period done

    assign wrap = ({5'h00, cnt_r} == (HALF_CYC - 1));
    assign blink_out = blink_r;

    // Count and flip the phase at each wrap
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= {`BLINK_CNT_W{1'b0}};
            blink_r <= 1'b0;
        end else if (wrap) begin
            cnt_r <= {`BLINK_CNT_W{1'b0}};
            blink_r <= ~blink_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // led_blink_div

// File: hw/led_trig_defines.vh
// Purpose: constants for the LED and trigger control bank
// Assumes: word registers, byte address = 4 x index
// Notes: reserved bits read as zero
`ifndef LED_TRIG_DEFINES_VH
`define LED_TRIG_DEFINES_VH

// Register indices
`define IDX_LED 10'h030
`define IDX_CTL2 10'h035
`define IDX_CTL2_B 10'h075
`define IDX_UTIL2 10'h010
`define IDX_UTIL3 10'h005
`define IDX_PPL_LO 10'h02c
`define IDX_PPL_HI 10'h02d

// LED register fields
`define LED_SEL_LSB 0
`define LED_SEL_MSB 1
`define LED_LEVEL 2
`define LED_MASK 8'h07
`define LED_RST 8'h00

// LED source codes (bit 1, bit 0)
`define LED_SLOW 2'b00
`define LED_FVAL 2'b10
`define LED_LVAL 2'b01
`define LED_STEADY 2'b11

// Control-2 fields
`define CTL2_SEPARATE_TRIGGER_EN 0
`define CTL2_EXPSEL 1
`define CTL2_FRMSRC 2
`define CTL2_FREERUN 3
`define CTL2_MARK 4
`define CTL2_COUNT 5
`define CTL2_MASK 8'h3f
`define CTL2_RST 8'h00

// Utility bits used here
`define UTIL2_TRIGSEL 7
`define UTIL2_MASK 8'h80
`define UTIL3_INV 0
`define UTIL3_MASK 8'h01
`define UTIL_RST 8'h00

// Frame marker bytes
`define MARK_B0 8'hff
`define MARK_B1 8'h00

// Blink timing
`define CLK_KHZ 200000
`define BLINK_HALF_MS 500
`define BLINK_HALF_CYC (`BLINK_HALF_MS * `CLK_KHZ)
`define BLINK_CNT_W 27

`endif

// File: hw/pix_buf2.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock
// Notes: a stalled sink stops the source at two words
`timescale 1ns/1ps
module pix_buf2 #(
    parameter integer WIDTH = 9
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_in,
    // Fill side
    input wire [WIDTH-1:0] in_data_in,
    input wire in_valid_in,
    output wire in_ready_out,
    // Drain side
    output wire [WIDTH-1:0] out_data_out,
    output wire out_valid_out,
    input wire out_ready_in
);
    reg [WIDTH-1:0] mem [0:1]; // Storage
    reg wr_ptr_r; // Next slot to fill
    reg rd_ptr_r; // Oldest slot
    reg [1:0] cnt_r; // Words held
    wire push;
    wire pop;

    assign in_ready_out = (cnt_r != 2'd2);
    assign out_valid_out = (cnt_r != 2'd0);
    assign out_data_out = mem[rd_ptr_r];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Storage has no reset; count guards it
    always @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_in;
        end
    end

    // Pointers and occupancy
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 2'd1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 2'd1;
            end
        end
    end
endmodule // pix_buf2

// File: sim/cam_source.sv
// Purpose: camera model giving frame, line and pixel bytes
// Assumes: one line per frame of len_in bytes
// Notes: idle data is the inverse of the last byte
`timescale 1ns/1ps
module cam_source (
    // Clock, reset and command
    input wire mclk_in,
    input wire rst_in,
    input wire go_in,
    input wire [7:0] len_in,
    input wire [7:0] base_in,
    // Camera side
    output reg fval_out,
    output reg lval_out,
    output reg [7:0] data_out,
    output reg sof_out,
    output reg valid_out,
    input wire ready_in
);
    reg [7:0] cnt_r; // Bytes issued so far
    // A byte stands until the grabber takes it
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            fval_out <= 1'b0;
            lval_out <= 1'b0;
            data_out <= 8'h00;
            sof_out <= 1'b0;
            valid_out <= 1'b0;
            cnt_r <= 8'h00;
        end else if (go_in && !fval_out) begin
            fval_out <= 1'b1;
            lval_out <= 1'b1;
            valid_out <= 1'b1;
            sof_out <= 1'b1;
            data_out <= base_in;
            cnt_r <= 8'h01;
        end else if (valid_out && ready_in) begin
            sof_out <= 1'b0;
            if (cnt_r == len_in) begin
                valid_out <= 1'b0;
                lval_out <= 1'b0;
                data_out <= ~data_out;
            end else begin
                data_out <= base_in + cnt_r;
                cnt_r <= cnt_r + 8'h01;
            end
        end else if (!lval_out) begin
            fval_out <= 1'b0; // Frame closes a cycle after the line
        end
    end
endmodule // cam_source

// File: sim/glt_properties.sv
// Purpose: port checker for the LED and trigger bank
// Assumes: one cycle output latency
// Notes: mirrors register writes to predict outputs
`timescale 1ns/1ps
`include "led_trig_defines.vh"
module glt_props (
    // Clock, reset and APB
    input wire mclk_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    // Camera, triggers and outputs
    input wire fval_in,
    input wire lval_in,
    input wire trigger_in_a,
    input wire trigger_in_b,
    input wire [1:0] shutter_in,
    input wire [1:0] exposure_out,
    input wire [1:0] trig_fire_out,
    input wire frame_trig_out,
    input wire [1:0] line_width_freerun_out,
    input wire led_out,
    input wire [7:0] pix_data_out,
    input wire pix_sof_out,
    input wire pix_valid_out
);
    reg [2:0] led_r; // Copy of the LED register
    reg [5:0] c_r; // Copy of primary control-2
    reg [5:0] cb_r; // Copy of secondary control-2
    reg u2_r; // Copy of the trigger select bit
    reg u3_r; // Copy of the trigger invert bit
    wire wr_w = psel_in && penable_in && pwrite_in && pstrb_in[0];
    // Mirror writes where the slave takes them
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            led_r <= 3'h0;
            c_r <= 6'h00;
            cb_r <= 6'h00;
            u2_r <= 1'b0;
            u3_r <= 1'b0;
        end else if (wr_w) begin
            if (paddr_in == {`IDX_LED, 2'b00}) led_r <= pwdata_in[2:0];
            if (paddr_in == {`IDX_CTL2, 2'b00}) c_r <= pwdata_in[5:0];
            if (paddr_in == {`IDX_CTL2_B, 2'b00}) cb_r <= pwdata_in[5:0];
            if (paddr_in == {`IDX_UTIL2, 2'b00}) u2_r <= pwdata_in[7];
            if (paddr_in == {`IDX_UTIL3, 2'b00}) u3_r <= pwdata_in[0];
        end
    end
    default clocking dc @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // $past guard skips the edge that still sees reset inputs
    exp_primary_a: assert property (!$past(rst_in) |-> exposure_out[0] == $past(shutter_in[0]))
        else $error("primary exposure mismatch");
    exp_secondary_a: assert property (!$past(rst_in) |-> exposure_out[1] == $past(c_r[1] ? shutter_in[0] : shutter_in[1]))
        else $error("secondary exposure mismatch");
    fire_route_a: assert property (!$past(rst_in) |-> trig_fire_out == $past({c_r[0] ? trigger_in_b : trigger_in_a, trigger_in_a}))
        else $error("trigger routing mismatch");
    frame_trig_a: assert property (!$past(rst_in) |-> frame_trig_out == $past(u2_r & (c_r[2] ? trigger_in_b : trigger_in_a ^ u3_r)))
        else $error("frame trigger mismatch");
    led_steady_a: assert property (!$past(rst_in) && $past(led_r[1:0]) == 2'b11 |-> led_out == $past(led_r[2]))
        else $error("steady LED mismatch");
    led_gated_a: assert property (!$past(rst_in) && ($past(led_r[1:0] == 2'b10 && !fval_in) || $past(led_r[1:0] == 2'b01 && !lval_in)) |-> !led_out)
        else $error("LED lit outside its gate");
    freerun_out_a: assert property (line_width_freerun_out == {cb_r[3], c_r[3]})
        else $error("free-run output mismatch");
    marker_tag_a: assert property (pix_valid_out && pix_sof_out && c_r[5:4] == 2'b01 |-> pix_data_out == `MARK_B0)
        else $error("frame marker byte mismatch");
endmodule // glt_props
bind grabber_led_trigger_ctrl glt_props u_props (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .fval_in(fval_in), .lval_in(lval_in),
    .trigger_in_a(trigger_in_a), .trigger_in_b(trigger_in_b), .shutter_in(shutter_in),
    .exposure_out(exposure_out), .trig_fire_out(trig_fire_out), .frame_trig_out(frame_trig_out),
    .line_width_freerun_out(line_width_freerun_out), .led_out(led_out), .pix_data_out(pix_data_out),
    .pix_sof_out(pix_sof_out), .pix_valid_out(pix_valid_out));

// File: sim/grabber_led_trigger_ctrl_tb_top.sv
// Purpose: bench for the LED and trigger bank
// Assumes: blink half period of 4 cycles
// Notes: a camera model feeds the pixel path
`timescale 1ns/1ps
`include "led_trig_defines.vh"
module grabber_led_trigger_ctrl_tb_top;
    localparam [11:0] A_LED = {`IDX_LED, 2'b00};
    localparam [11:0] A_C2 = {`IDX_CTL2, 2'b00};
    localparam [11:0] A_C2B = {`IDX_CTL2_B, 2'b00};
    reg mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    reg trig_a = 1'b0, trig_b = 1'b0, pix_ready = 1'b0, stall = 1'b1, er;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [1:0] shutter = 2'h0;
    reg [7:0] base = 8'h00;
    reg [8:0] rxq[$]; // Bytes seen leaving the buffer, with start flag
    wire [31:0] prdata;
    wire pready, pslverr, fval, lval, sof, valid, ready_o, led, ftrig, ps, pv;
    wire [7:0] data, pd;
    wire [1:0] expo, fire, lwf;
    integer err_total = 0, comparisons = 0, cycles = 0, m, v, t;
    always #2.5 mclk_in = ~mclk_in;
    grabber_led_trigger_ctrl #(.BLINK_HALF_CYC(4)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .fval_in(fval), .lval_in(lval), .pix_data_in(data), .pix_sof_in(sof),
        .pix_valid_in(valid), .pix_ready_out(ready_o), .pix_data_out(pd), .pix_sof_out(ps),
        .pix_valid_out(pv), .pix_ready_in(pix_ready), .trigger_in_a(trig_a), .trigger_in_b(trig_b),
        .shutter_in(shutter), .exposure_out(expo), .trig_fire_out(fire), .frame_trig_out(ftrig),
        .line_width_freerun_out(lwf), .led_out(led));
    cam_source CAM (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go), .len_in(8'h04), .base_in(base),
        .fval_out(fval), .lval_out(lval), .data_out(data), .sof_out(sof), .valid_out(valid),
        .ready_in(ready_o));
    // Sink stalls every other cycle while draining
    always @(posedge mclk_in) pix_ready <= stall ? 1'b0 : ~pix_ready;
    always @(negedge mclk_in) if (pv === 1'b1 && pix_ready === 1'b1) rxq.push_back({ps, pd});
    task wrap_up;
        begin
            $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer, held until pready is seen high
    task apb(input [11:0] a, input w, input [7:0] d);
        begin
            @(posedge mclk_in);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h000000, d};
            @(posedge mclk_in);
            penable <= 1'b1;
            @(posedge mclk_in);
            while (pready !== 1'b1) @(posedge mclk_in);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rchk(input [11:0] a, input [31:0] exp, input e);
        begin
            apb(a, 1'b0, 8'h00);
            chk(rd, exp);
            chk(er, e);
        end
    endtask
    task gap(input integer n);
        repeat (n) @(negedge mclk_in);
    endtask
    task toggles(input integer n, output integer c);
        reg p;
        begin
            c = 0;
            repeat (n) begin
                p = led;
                @(negedge mclk_in);
                c = c + (led !== p);
            end
        end
    endtask
    always @(posedge mclk_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: run timed out", $time);
            wrap_up;
        end
    end
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        rchk(A_LED, 32'h0, 1'b0);
        rchk(A_C2, 32'h0, 1'b0);
        apb(A_LED, 1'b1, 8'hff);
        rchk(A_LED, 32'h7, 1'b0);
        apb(A_C2B, 1'b1, 8'hea);
        rchk(A_C2B, 32'h2a, 1'b0);
        rchk(A_C2, 32'h0, 1'b0);
        rchk(A_LED + 12'h004, 32'h0, 1'b1);
        apb(A_LED + 12'h001, 1'b1, 8'h00);
        chk(er, 1'b1);
        rchk(A_LED, 32'h7, 1'b0);
        chk(lwf, 2'b10);
        $display("Register test done");
        chk(led, 1'b1);
        apb(A_LED, 1'b1, 8'h03);
        gap(2);
        chk(led, 1'b0);
        apb(A_LED, 1'b1, 8'h00);
        toggles(24, t);
        chk(t >= 5 && t <= 7, 1'b1);
        apb(A_LED, 1'b1, 8'h02);
        gap(2);
        toggles(16, t);
        chk(t, 0);
        $display("LED test done");
        for (v = 0; v < 512; v = v + 1) begin
            if (v[3:0] == 4'h0) begin
                apb(A_C2, 1'b1, {5'h00, v[6:4]});
                apb({`IDX_UTIL3, 2'b00}, 1'b1, {7'h00, v[7]});
                apb({`IDX_UTIL2, 2'b00}, 1'b1, {v[8], 7'h00});
            end
            @(posedge mclk_in);
            {trig_b, trig_a, shutter} <= v[3:0];
            gap(2);
            chk(expo, {v[5] ? v[0] : v[1], v[0]});
            chk(fire, {v[4] ? v[3] : v[2], v[2]});
            chk(ftrig, v[8] & (v[6] ? v[3] : v[2] ^ v[7]));
        end
        $display("Trigger test done");
        for (m = 0; m < 4; m = m + 1) begin
            apb(A_C2, 1'b1, {2'b00, m[1:0], 4'h0});
            @(posedge mclk_in);
            go <= 1'b1;
            base <= {2'b01, m[1:0], 4'h3};
            @(posedge mclk_in);
            go <= 1'b0;
            gap(8);
            chk(ready_o, 1'b0);
            chk(pv, 1'b1);
            for (v = 1; v < 3 && m == 0; v = v + 1) begin
                apb(A_LED, 1'b1, v[7:0]);
                toggles(24, t);
                chk(t >= 4, 1'b1);
            end
            stall = 1'b0;
            while (rxq.size() < 4) @(negedge mclk_in);
            gap(4);
            chk(rxq.size(), 4);
            chk(rxq[0], {1'b1, m[1] ? m[7:0] : m[0] ? `MARK_B0 : base});
            chk(rxq[1], {1'b0, m[1] ? m[15:8] : m[0] ? `MARK_B1 : base + 8'h01});
            chk(rxq[2], {1'b0, base + 8'h02});
            chk(rxq[3], {1'b0, base + 8'h03});
            if (m == 0) rchk({`IDX_PPL_LO, 2'b00}, 32'h4, 1'b0);
            rxq.delete();
            stall = 1'b1;
        end
        apb(A_C2, 1'b1, 8'h08);
        gap(2);
        chk(lwf, 2'b11);
        $display("Stream test done");
        wrap_up;
    end
endmodule // grabber_led_trigger_ctrl_tb_top
